//--- core/sdc_map.svh
// named offsets, field positions, encodings and reset values of the segment type checker
// assumes it is included by bare name from the core/ files
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH

// ---------------------------------------------
// fields of the descriptor's second doubleword
// ---------------------------------------------
`define SDC_TYPE_LSB 8
`define SDC_TYPE_MSB 11
`define SDC_CLASS_BIT 12
`define SDC_DPL_LSB 13
`define SDC_DPL_MSB 14

// ---------------------------------------------
// bit positions inside the four-bit type field
// ---------------------------------------------
`define SDC_T_ACC 0
`define SDC_T_WR 1
`define SDC_T_RD 1
`define SDC_T_DOWN 2
`define SDC_T_CONF 2
`define SDC_T_CODE 3
`define SDC_T_WIDE 3

// ---------------------------------------------
// system type encodings
// ---------------------------------------------
`define SDC_SYS_TSS16_AVL 4'h1
`define SDC_SYS_LDT 4'h2
`define SDC_SYS_TSS16_BSY 4'h3
`define SDC_SYS_CALL16 4'h4
`define SDC_SYS_TASK 4'h5
`define SDC_SYS_INTR16 4'h6
`define SDC_SYS_TRAP16 4'h7
`define SDC_SYS_TSS32_AVL 4'h9
`define SDC_SYS_TSS32_BSY 4'hB
`define SDC_SYS_CALL32 4'hC
`define SDC_SYS_INTR32 4'hE
`define SDC_SYS_TRAP32 4'hF

// ---------------------------------------------
// segment register indices and reset values
// ---------------------------------------------
`define SDC_NUM_SEGS 6
`define SDC_SEG_W 3
`define SDC_SEG_CODE 3'h0
`define SDC_SEG_STACK 3'h1
`define SDC_SEG_DATA 3'h2
`define SDC_SEG_EXTRA 3'h3
`define SDC_SEG_THIRD 3'h4
`define SDC_SEG_FOURTH 3'h5
`define SDC_CPL_RESET 2'h0
`define SDC_WORD_RESET 32'h0000_0000

`endif

//--- core/sdc_pkg.sv
// types shared by the segment type decoder, the accessed write-back unit and the checker
// assumes nothing beyond a SystemVerilog compiler
package sdc_pkg;

   // ---------------------------------------------
   // descriptor kinds and decoded attributes
   // ---------------------------------------------
   typedef enum logic [2:0] {
      SDC_KIND_NONE = 3'h0,
      SDC_KIND_LDT = 3'h1,
      SDC_KIND_TSS = 3'h2,
      SDC_KIND_CALL = 3'h3,
      SDC_KIND_TASK = 3'h4,
      SDC_KIND_INTR = 3'h5,
      SDC_KIND_TRAP = 3'h6
   } sdc_kind_type;

   typedef struct packed {
      logic is_system;
      logic is_code;
      logic is_data;
      logic accessed;
      logic writable;
      logic grow_down;
      logic readable;
      logic conforming;
      logic reserved;
      logic sys_segment;
      logic is_gate;
      logic wide32;
      logic busy;
      sdc_kind_type kind;
   } sdc_attr_type;

   // ---------------------------------------------
   // requests from the core
   // ---------------------------------------------
   typedef struct packed {
      logic [2:0] target;
      logic via_gate;
      logic [31:0] word;
   } sdc_load_type;

   typedef struct packed {
      logic [2:0] target;
      logic write;
   } sdc_access_type;

   // ---------------------------------------------
   // fault causes and write-back states
   // ---------------------------------------------
   typedef enum logic [3:0] {
      SDC_CAUSE_NONE = 4'h0,
      SDC_CAUSE_STACK_RO = 4'h1,
      SDC_CAUSE_STACK_KIND = 4'h2,
      SDC_CAUSE_EXEC_ONLY_LOAD = 4'h3,
      SDC_CAUSE_SYSTEM = 4'h4,
      SDC_CAUSE_PRIV = 4'h5,
      SDC_CAUSE_NOT_CODE = 4'h6,
      SDC_CAUSE_CODE_WRITE = 4'h7,
      SDC_CAUSE_EXEC_ONLY_READ = 4'h8,
      SDC_CAUSE_DATA_RO_WRITE = 4'h9,
      SDC_CAUSE_UNLOADED = 4'hA
   } sdc_cause_type;

   typedef enum logic [1:0] {
      SDC_WB_IDLE = 2'b01,
      SDC_WB_WRITE = 2'b10
   } sdc_wb_state_type;

endpackage

//--- core/sdc_type_decode.sv
// combinational decode of the class flag and type field of a descriptor
// assumes the second doubleword of the descriptor is presented whole
`include "sdc_map.svh"

module sdc_type_decode (
   input wire logic [31:0] desc_word_in,
   output sdc_pkg::sdc_attr_type attr_out
);

   logic [3:0] t;
   logic s;

   always_comb
   begin
      t = desc_word_in[`SDC_TYPE_MSB:`SDC_TYPE_LSB];
      s = desc_word_in[`SDC_CLASS_BIT];
      attr_out = '0;
      attr_out.kind = sdc_pkg::SDC_KIND_NONE;
      attr_out.is_system = !s;
      attr_out.is_code = s && t[`SDC_T_CODE];
      attr_out.is_data = s && !t[`SDC_T_CODE];
      if (s)
      begin
         attr_out.accessed = t[`SDC_T_ACC];
         attr_out.writable = !t[`SDC_T_CODE] && t[`SDC_T_WR];
         attr_out.grow_down = !t[`SDC_T_CODE] && t[`SDC_T_DOWN];
         attr_out.readable = !t[`SDC_T_CODE] || t[`SDC_T_RD];
         // data is never conforming
         attr_out.conforming = t[`SDC_T_CODE] && t[`SDC_T_CONF];
      end
      else
      begin
         attr_out.wide32 = t[`SDC_T_WIDE];
         case (t)
            `SDC_SYS_LDT:
            begin
               attr_out.kind = sdc_pkg::SDC_KIND_LDT;
               attr_out.sys_segment = 1'b1;
            end
            `SDC_SYS_TSS16_AVL, `SDC_SYS_TSS32_AVL:
            begin
               attr_out.kind = sdc_pkg::SDC_KIND_TSS;
               attr_out.sys_segment = 1'b1;
            end
            `SDC_SYS_TSS16_BSY, `SDC_SYS_TSS32_BSY:
            begin
               attr_out.kind = sdc_pkg::SDC_KIND_TSS;
               attr_out.sys_segment = 1'b1;
               attr_out.busy = 1'b1;
            end
            `SDC_SYS_CALL16, `SDC_SYS_CALL32:
            begin
               attr_out.kind = sdc_pkg::SDC_KIND_CALL;
               attr_out.is_gate = 1'b1;
            end
            `SDC_SYS_TASK:
            begin
               attr_out.kind = sdc_pkg::SDC_KIND_TASK;
               attr_out.is_gate = 1'b1;
            end
            `SDC_SYS_INTR16, `SDC_SYS_INTR32:
            begin
               attr_out.kind = sdc_pkg::SDC_KIND_INTR;
               attr_out.is_gate = 1'b1;
            end
            `SDC_SYS_TRAP16, `SDC_SYS_TRAP32:
            begin
               attr_out.kind = sdc_pkg::SDC_KIND_TRAP;
               attr_out.is_gate = 1'b1;
            end
            default:
            begin
               attr_out.reserved = 1'b1;
            end
         endcase
      end
   end

endmodule

//--- core/sdc_accessed_wb.sv
// accessed-flag write-back sequencer: one descriptor write cycle per request
// assumes cycle_done_in is already synchronised to clk_in
`include "sdc_map.svh"

module sdc_accessed_wb (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic start_in,
   input wire logic [31:0] word_in,
   input wire logic cycle_done_in,
   output logic write_req_out,
   output logic [31:0] write_word_out,
   output logic idle_out
);

   sdc_pkg::sdc_wb_state_type state_q;

   // ---------------------------------------------
   // state
   // ---------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_q <= sdc_pkg::SDC_WB_IDLE;
      end
      else
      begin
         case (state_q)
            sdc_pkg::SDC_WB_IDLE:
            begin
               if (start_in)
               begin
                  state_q <= sdc_pkg::SDC_WB_WRITE;
               end
            end
            sdc_pkg::SDC_WB_WRITE:
            begin
               // the write ends only on cycle-done, even if nothing drives the bus
               if (cycle_done_in)
               begin
                  state_q <= sdc_pkg::SDC_WB_IDLE;
               end
            end
            default:
            begin
               state_q <= sdc_pkg::SDC_WB_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         write_req_out <= 1'b0;
         write_word_out <= `SDC_WORD_RESET;
         idle_out <= 1'b1;
      end
      else if (state_q == sdc_pkg::SDC_WB_IDLE && start_in)
      begin
         write_req_out <= 1'b1;
         write_word_out <= word_in | (32'h0000_0001 << (`SDC_TYPE_LSB + `SDC_T_ACC));
         idle_out <= 1'b0;
      end
      else if (state_q == sdc_pkg::SDC_WB_WRITE && cycle_done_in)
      begin
         write_req_out <= 1'b0;
         idle_out <= 1'b1;
      end
   end

endmodule

//--- core/sdc_check.sv
// segment type decode and protection checks on segment-register loads and accesses
// assumes loads and accesses come from core logic on clk_in; cycle_done_in is a pin
`include "sdc_map.svh"

module sdc_check #(
   parameter int NUM_SEGS = `SDC_NUM_SEGS
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic protected_mode_in,
   input wire logic [1:0] cpl_in,
   input wire logic load_valid_in,
   input wire sdc_pkg::sdc_load_type load_in,
   input wire logic access_valid_in,
   input wire sdc_pkg::sdc_access_type access_in,
   input wire logic cycle_done_in,
   output logic load_ready_out,
   output sdc_pkg::sdc_attr_type attr_out,
   output logic load_done_out,
   output logic general_protection_fault_out,
   output sdc_pkg::sdc_cause_type fault_cause_out,
   output logic cpl_update_out,
   output logic [1:0] new_cpl_out,
   output logic access_ok_out,
   output logic desc_write_req_out,
   output logic [31:0] desc_write_word_out
);

   // ---------------------------------------------
   // declarations
   // ---------------------------------------------
   sdc_pkg::sdc_attr_type dec_attr;
   sdc_pkg::sdc_attr_type cache_q [NUM_SEGS];
   logic [NUM_SEGS-1:0] cache_valid_q;
   logic done_meta_q;
   logic done_sync_q;
   logic wb_idle;
   logic load_take;
   logic load_fault;
   logic wb_start;
   logic [1:0] dpl;
   logic [1:0] cpl_next;
   sdc_pkg::sdc_cause_type load_cause;
   sdc_pkg::sdc_cause_type access_cause;
   sdc_pkg::sdc_attr_type acc_attr;
   logic acc_valid;

   // ---------------------------------------------
   // type decode
   // ---------------------------------------------
   sdc_type_decode u_decode (
      .desc_word_in (load_in.word),
      .attr_out (dec_attr)
   );

   assign dpl = load_in.word[`SDC_DPL_MSB:`SDC_DPL_LSB];
   assign load_take = load_valid_in && wb_idle;

   // ---------------------------------------------
   // load checks
   // ---------------------------------------------
   always_comb
   begin
      load_cause = sdc_pkg::SDC_CAUSE_NONE;
      cpl_next = cpl_in;
      if (dec_attr.is_system)
      begin
         // gates and system segments are reached by other paths, never by a segment load
         load_cause = sdc_pkg::SDC_CAUSE_SYSTEM;
      end
      else
      begin
         case (load_in.target)
            `SDC_SEG_CODE:
            begin
               if (!dec_attr.is_code)
               begin
                  load_cause = sdc_pkg::SDC_CAUSE_NOT_CODE;
               end
               else if (dec_attr.conforming)
               begin
                  // less privileged conforming code is refused; privilege stays put
                  if (dpl > cpl_in)
                  begin
                     load_cause = sdc_pkg::SDC_CAUSE_PRIV;
                  end
                  cpl_next = cpl_in;
               end
               else
               begin
                  if (dpl != cpl_in && !load_in.via_gate)
                  begin
                     load_cause = sdc_pkg::SDC_CAUSE_PRIV;
                  end
                  cpl_next = dpl;
               end
            end
            `SDC_SEG_STACK:
            begin
               if (!dec_attr.is_data)
               begin
                  load_cause = sdc_pkg::SDC_CAUSE_STACK_KIND;
               end
               else if (!dec_attr.writable)
               begin
                  load_cause = sdc_pkg::SDC_CAUSE_STACK_RO;
               end
            end
            default:
            begin
               // data needs no gate at any level; code must be readable
               if (dec_attr.is_code && !dec_attr.readable)
               begin
                  load_cause = sdc_pkg::SDC_CAUSE_EXEC_ONLY_LOAD;
               end
            end
         endcase
      end
   end

   assign load_fault = protected_mode_in && load_cause != sdc_pkg::SDC_CAUSE_NONE;
   // no write cycle when the flag is set already, which spares rom tables
   assign wb_start = load_take && protected_mode_in && !load_fault && !dec_attr.accessed;

   // ---------------------------------------------
   // cached attributes, one entry per segment register
   // ---------------------------------------------
   for (genvar g = 0; g < NUM_SEGS; g++)
   begin : g_cache
      always_ff @(posedge clk_in or negedge rst_n_in)
      begin
         if (!rst_n_in)
         begin
            cache_q[g] <= '0;
            cache_valid_q[g] <= 1'b0;
         end
         else if (load_take && !load_fault && load_in.target == `SDC_SEG_W'(g))
         begin
            cache_q[g] <= dec_attr;
            cache_q[g].accessed <= 1'b1;
            cache_valid_q[g] <= 1'b1;
         end
      end
   end

   // ---------------------------------------------
   // access checks
   // ---------------------------------------------
   always_comb
   begin
      acc_attr = '0;
      acc_valid = 1'b0;
      for (int i = 0; i < NUM_SEGS; i++)
      begin
         if (access_in.target == `SDC_SEG_W'(i))
         begin
            acc_attr = cache_q[i];
            acc_valid = cache_valid_q[i];
         end
      end
      access_cause = sdc_pkg::SDC_CAUSE_NONE;
      if (!acc_valid)
      begin
         access_cause = sdc_pkg::SDC_CAUSE_UNLOADED;
      end
      else if (access_in.write && acc_attr.is_code)
      begin
         access_cause = sdc_pkg::SDC_CAUSE_CODE_WRITE;
      end
      else if (access_in.write && !acc_attr.writable)
      begin
         access_cause = sdc_pkg::SDC_CAUSE_DATA_RO_WRITE;
      end
      else if (!access_in.write && !acc_attr.readable)
      begin
         access_cause = sdc_pkg::SDC_CAUSE_EXEC_ONLY_READ;
      end
   end

   // ---------------------------------------------
   // registered results
   // ---------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         general_protection_fault_out <= 1'b0;
         fault_cause_out <= sdc_pkg::SDC_CAUSE_NONE;
         load_done_out <= 1'b0;
         access_ok_out <= 1'b0;
      end
      else
      begin
         load_done_out <= load_take;
         general_protection_fault_out <= 1'b0;
         access_ok_out <= 1'b0;
         // a load fault wins the cause field over a same-cycle access fault
         if (load_take && load_fault)
         begin
            general_protection_fault_out <= 1'b1;
            fault_cause_out <= load_cause;
         end
         else if (access_valid_in && protected_mode_in && access_cause != sdc_pkg::SDC_CAUSE_NONE)
         begin
            general_protection_fault_out <= 1'b1;
            fault_cause_out <= access_cause;
         end
         if (access_valid_in && (!protected_mode_in || access_cause == sdc_pkg::SDC_CAUSE_NONE))
         begin
            access_ok_out <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         attr_out <= '0;
      end
      else if (load_take)
      begin
         attr_out <= dec_attr;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cpl_update_out <= 1'b0;
         new_cpl_out <= `SDC_CPL_RESET;
      end
      else
      begin
         cpl_update_out <= 1'b0;
         if (load_take && protected_mode_in && !load_fault && load_in.target == `SDC_SEG_CODE)
         begin
            cpl_update_out <= 1'b1;
            new_cpl_out <= cpl_next;
         end
      end
   end

   // ---------------------------------------------
   // cycle-done synchroniser and write-back
   // ---------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         done_meta_q <= 1'b0;
         done_sync_q <= 1'b0;
      end
      else
      begin
         done_meta_q <= cycle_done_in;
         done_sync_q <= done_meta_q;
      end
   end

   sdc_accessed_wb u_wb (
      .clk_in (clk_in),
      .rst_n_in (rst_n_in),
      .start_in (wb_start),
      .word_in (load_in.word),
      .cycle_done_in (done_sync_q),
      .write_req_out (desc_write_req_out),
      .write_word_out (desc_write_word_out),
      .idle_out (wb_idle)
   );

   // loads stall while a write-back is outstanding
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         load_ready_out <= 1'b1;
      end
      else
      begin
         load_ready_out <= !(wb_start || (!wb_idle && !(done_sync_q)));
      end
   end

endmodule

//--- test/sdc_check_props.sv
// concurrent checks on the ports of the segment type checker
// assumes it is bound to sdc_check and that sdc_pkg is compiled first
module sdc_check_props #(
   parameter int NUM_SEGS = 6
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic protected_mode_in,
   input wire logic [1:0] cpl_in,
   input wire logic load_valid_in,
   input wire sdc_pkg::sdc_load_type load_in,
   input wire logic access_valid_in,
   input wire sdc_pkg::sdc_access_type access_in,
   input wire logic cycle_done_in,
   input wire logic load_ready_out,
   input wire sdc_pkg::sdc_attr_type attr_out,
   input wire logic load_done_out,
   input wire logic general_protection_fault_out,
   input wire sdc_pkg::sdc_cause_type fault_cause_out,
   input wire logic cpl_update_out,
   input wire logic [1:0] new_cpl_out,
   input wire logic access_ok_out,
   input wire logic desc_write_req_out,
   input wire logic [31:0] desc_write_word_out
);
   // ---------------------------------------------
   // load qualifiers
   // ---------------------------------------------
   logic tk;
   logic pm_tk;
   logic [31:0] w;
   assign w = load_in.word;
   assign tk = load_valid_in && load_ready_out;
   assign pm_tk = tk && protected_mode_in;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_load_answer: assert property (tk |=> load_done_out)
      else $error("load not answered after one cycle");
   a_class_decode: assert property (tk |=> attr_out.is_code == $past(w[12] & w[11])
      && attr_out.is_system == !$past(w[12]))
      else $error("class decode wrong");
   a_data_flags: assert property (tk && w[12] && !w[11] |=>
      {attr_out.grow_down, attr_out.writable} == $past(w[10:9]))
      else $error("data flags wrong");
   a_code_flags: assert property (tk && w[12] && w[11] |=>
      {attr_out.conforming, attr_out.readable} == $past(w[10:9]))
      else $error("code flags wrong");
   a_stack_ro: assert property (pm_tk && load_in.target == 3'h1 && w[12] && !w[11] && !w[9] |=>
      general_protection_fault_out && fault_cause_out == sdc_pkg::SDC_CAUSE_STACK_RO)
      else $error("read-only stack load not faulted");
   a_system_load: assert property (pm_tk && !w[12] |=>
      general_protection_fault_out && fault_cause_out == sdc_pkg::SDC_CAUSE_SYSTEM)
      else $error("system descriptor load not faulted");
   a_nonconf_priv: assert property (pm_tk && load_in.target == 3'h0 && w[12] && w[11] && !w[10]
      && w[14:13] != cpl_in && !load_in.via_gate |=> general_protection_fault_out
      && fault_cause_out == sdc_pkg::SDC_CAUSE_PRIV)
      else $error("direct transfer to other level not faulted");
   a_conf_keep: assert property (pm_tk && load_in.target == 3'h0 && w[12] && w[11] && w[10]
      && w[14:13] <= cpl_in |=> cpl_update_out && new_cpl_out == $past(cpl_in))
      else $error("conforming transfer changed level");
   a_wb_start: assert property (pm_tk && load_in.target == 3'h2 && w[12] && !w[11] && !w[8] |=>
      desc_write_req_out && desc_write_word_out == ($past(w) | 32'h0000_0100))
      else $error("accessed write-back missing");
   a_wb_skip: assert property (pm_tk && w[8] && !desc_write_req_out |=> !desc_write_req_out)
      else $error("write-back of an accessed descriptor");
   a_wb_hold: assert property (desc_write_req_out && $past(desc_write_req_out) |->
      $stable(desc_write_word_out))
      else $error("write-back word moved");
   a_wb_ends: assert property (desc_write_req_out && cycle_done_in |-> ##[1:4] !desc_write_req_out)
      else $error("write cycle not ended by cycle-done");
   a_code_write: assert property (access_valid_in && access_in.write && access_in.target == 3'h0
      && protected_mode_in |=> general_protection_fault_out)
      else $error("write through code register allowed");
endmodule

//--- test/sdc_check_test.sv
// self-checking bench for the segment type checker, random stimulus from a fixed lfsr seed
// assumes sdc_pkg and the core files are compiled first
module sdc_check_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0;
   logic rst_n_in = 0;
   logic protected_mode_in = 1;
   logic [1:0] cpl_in = 2'h0;
   logic load_valid_in = 0;
   sdc_pkg::sdc_load_type load_in = '0;
   logic access_valid_in = 0;
   sdc_pkg::sdc_access_type access_in = '0;
   logic cycle_done_in = 0;
   logic load_ready_out, load_done_out, general_protection_fault_out, cpl_update_out;
   logic access_ok_out, desc_write_req_out;
   sdc_pkg::sdc_attr_type attr_out;
   sdc_pkg::sdc_cause_type fault_cause_out;
   logic [1:0] new_cpl_out;
   logic [31:0] desc_write_word_out;
   int num_errors = 0;
   int total_checks = 0;
   logic [15:0] rnd = 16'h0027;
   logic cv[6] = '{default: 0};
   logic [31:0] cw[6];

   sdc_check #(.NUM_SEGS(6)) sdc_check_i (.clk_in, .rst_n_in, .protected_mode_in, .cpl_in, .load_valid_in, .load_in,
      .access_valid_in, .access_in, .cycle_done_in, .load_ready_out, .attr_out, .load_done_out,
      .general_protection_fault_out, .fault_cause_out, .cpl_update_out, .new_cpl_out, .access_ok_out,
      .desc_write_req_out, .desc_write_word_out);

   initial
   begin
      forever #2 clk_in = ~clk_in;
   end

   // ---------------------------------------------
   // expectation helpers
   // ---------------------------------------------
   function automatic logic [31:0] mk(input logic c, input logic [1:0] d, input logic [3:0] t);
      return {17'h0_0000, d, c, t, 8'h00};
   endfunction
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [2:0] tg(input logic [15:0] s);
      return s[2:0] > 3'h5 ? {1'b0, s[4:3]} : s[2:0];
   endfunction
   function automatic sdc_pkg::sdc_kind_type kind_of(input logic [3:0] t);
      case (t)
         4'h1, 4'h3, 4'h9, 4'hB: return sdc_pkg::SDC_KIND_TSS;
         4'h2: return sdc_pkg::SDC_KIND_LDT;
         4'h4, 4'hC: return sdc_pkg::SDC_KIND_CALL;
         4'h5: return sdc_pkg::SDC_KIND_TASK;
         4'h6, 4'hE: return sdc_pkg::SDC_KIND_INTR;
         4'h7, 4'hF: return sdc_pkg::SDC_KIND_TRAP;
         default: return sdc_pkg::SDC_KIND_NONE;
      endcase
   endfunction
   // reads cpl and mode straight from the driven inputs, so call it only once they have settled
   function automatic sdc_pkg::sdc_cause_type ld_cause(input logic [2:0] t, input logic g, input logic [31:0] w);
      if (!protected_mode_in) return sdc_pkg::SDC_CAUSE_NONE;
      if (!w[12]) return sdc_pkg::SDC_CAUSE_SYSTEM;
      if (t == 3'h0) return !w[11] ? sdc_pkg::SDC_CAUSE_NOT_CODE : (w[10] ? w[14:13] > cpl_in :
         w[14:13] != cpl_in && !g) ? sdc_pkg::SDC_CAUSE_PRIV : sdc_pkg::SDC_CAUSE_NONE;
      if (t == 3'h1) return w[11] ? sdc_pkg::SDC_CAUSE_STACK_KIND : w[9] ? sdc_pkg::SDC_CAUSE_NONE :
         sdc_pkg::SDC_CAUSE_STACK_RO;
      return w[11] && !w[9] ? sdc_pkg::SDC_CAUSE_EXEC_ONLY_LOAD : sdc_pkg::SDC_CAUSE_NONE;
   endfunction

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask

   // ---------------------------------------------
   // load and access drivers
   // ---------------------------------------------
   task automatic ld(input logic [2:0] t, input logic g, input logic [31:0] w);
      sdc_pkg::sdc_cause_type ec;
      logic ok;
      int n;
      n = 0;
      @(posedge clk_in);
      load_valid_in <= 1;
      load_in <= {t, g, w};
      @(negedge clk_in);
      ec = ld_cause(t, g, w);
      ok = ec == sdc_pkg::SDC_CAUSE_NONE;
      while (load_ready_out !== 1'b1 && n < 50)
      begin
         n++;
         @(negedge clk_in);
      end
      @(posedge clk_in);
      load_valid_in <= 0;
      @(negedge clk_in);
      chk("load_done", 1, load_done_out);
      chk("load_fault", !ok, general_protection_fault_out);
      if (!ok) chk("load_cause", ec, fault_cause_out);
      chk("class", {w[12] & w[11], !w[12]}, {attr_out.is_code, attr_out.is_system});
      if (w[12]) chk("accessed", w[8], attr_out.accessed);
      if (w[12]) chk("flags", w[11] ? {w[9], w[10], 2'b00} : {2'b10, w[9], w[10]}, {attr_out.readable,
         attr_out.conforming, attr_out.writable, attr_out.grow_down});
      else chk("kind", kind_of(w[11:8]), attr_out.kind);
      if (t == 3'h0 && ok && protected_mode_in) chk("new_cpl", w[10] ? cpl_in : w[14:13], new_cpl_out);
      ok = ok && protected_mode_in;
      if (ok) cv[t] = 1;
      if (ok) cw[t] = w;
      chk("wb_req", ok && !w[8], desc_write_req_out);
      if (!ok || w[8]) return;
      chk("wb_word", w | 32'h0000_0100, desc_write_word_out);
      @(posedge clk_in);
      cycle_done_in <= 1;
      n = 0;
      @(negedge clk_in);
      while (desc_write_req_out !== 1'b0 && n < 20)
      begin
         n++;
         @(negedge clk_in);
      end
      chk("wb_end", 0, desc_write_req_out);
      @(posedge clk_in);
      cycle_done_in <= 0;
      // let the synchronised cycle-done drain so it cannot end the next write early
      repeat (3) @(posedge clk_in);
   endtask

   task automatic ac(input logic [2:0] t, input logic wr);
      sdc_pkg::sdc_cause_type ec;
      logic [31:0] w;
      w = cw[t];
      ec = !cv[t] ? sdc_pkg::SDC_CAUSE_UNLOADED : w[11] ? (wr ? sdc_pkg::SDC_CAUSE_CODE_WRITE : !w[9] ?
         sdc_pkg::SDC_CAUSE_EXEC_ONLY_READ : sdc_pkg::SDC_CAUSE_NONE) : wr && !w[9] ?
         sdc_pkg::SDC_CAUSE_DATA_RO_WRITE : sdc_pkg::SDC_CAUSE_NONE;
      @(posedge clk_in);
      access_valid_in <= 1;
      access_in <= {t, wr};
      @(posedge clk_in);
      access_valid_in <= 0;
      @(negedge clk_in);
      chk("access_ok", ec == sdc_pkg::SDC_CAUSE_NONE, access_ok_out);
      if (ec != sdc_pkg::SDC_CAUSE_NONE) chk("access_cause", ec, fault_cause_out);
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      #100000;
      num_errors++;
      finish_test();
   end

   initial
   begin
      repeat (20) @(posedge clk_in);
      rst_n_in <= 1;
      for (int i = 0; i < 6; i++) ac(i[2:0], i[0]);
      $display("test unloaded access done");
      for (int i = 0; i < 16; i++)
      begin
         rnd = nx(rnd);
         ld(tg(rnd), 1'b0, mk(1'b0, rnd[6:5], i[3:0]));
      end
      $display("test system kinds done");
      for (int i = 0; i < 16; i++)
      begin
         ld(3'h2, 1'b0, mk(1'b1, 2'h3, i[3:0]));
         ac(3'h2, 1'b0);
         ac(3'h2, 1'b1);
         ld(3'h1, 1'b0, mk(1'b1, 2'h0, i[3:0]));
      end
      $display("test code and data types done");
      for (int i = 0; i < 96; i++)
      begin
         rnd = nx(rnd);
         @(posedge clk_in);
         cpl_in <= rnd[8:7];
         if (i[0]) ld(3'h0, rnd[9], mk(1'b1, rnd[12:11], {1'b1, rnd[15:13]}));
         else ld(tg(rnd), rnd[9], mk(rnd[10], rnd[12:11], rnd[15:12]));
         ac(tg(nx(rnd)), rnd[5]);
      end
      $display("test random traffic done");
      @(posedge clk_in);
      protected_mode_in <= 0;
      ld(3'h1, 1'b0, mk(1'b1, 2'h0, 4'h0));
      $display("test unprotected load done");
      finish_test();
   end
endmodule

bind sdc_check sdc_check_props #(.NUM_SEGS(NUM_SEGS)) sdc_check_props_i (.clk_in, .rst_n_in, .protected_mode_in,
   .cpl_in, .load_valid_in, .load_in, .access_valid_in, .access_in, .cycle_done_in, .load_ready_out, .attr_out,
   .load_done_out, .general_protection_fault_out, .fault_cause_out, .cpl_update_out, .new_cpl_out, .access_ok_out,
   .desc_write_req_out, .desc_write_word_out);
